// ---- verilog/gmm_pkg.sv ----
// Purpose: constants, types and register map of the GMII/MII MAC link setup block
// Assumes: one 25 MHz system clock, PHY clocks sampled as plain inputs
// Notes:   register offsets are byte addresses on the plain register port
//
// Function
// RL1 - 10/100 runs half or full duplex; 1000 always runs full duplex.
// RL2 - gigabit drives eight data bits, enable and error on MAC-made transmit clock.
// RL3 - gigabit receive takes eight bits, valid and error on PHY receive clock.
// RL4 - 10/100 drives four data bits timed by the PHY transmit clock.
// RL5 - 10/100 receive uses only the low nibble of the receive bus.
// RL6 - no management pins; software pins offered to emulate PHY register access.
// RL7 - no PHY speed/duplex pins; duplex forced, rate forced or auto-detected.
// RL8 - board holds factory test selects low and diagnostic input high.
// RL9 - port runs GMII/MII only when interface select equals 01.
// RL10 - forced duplex takes software setting; reported duplex mirrors it.
// RL11 - forced rate uses software rate field; status mirrors it.
// RL12 - unforced with auto-detect on, rate computed from PHY clocks and reported.
// RL13 - link up status is PHY link input ANDed with link attach enable.
// RL14 - without link attach enable the PHY link is ignored, no traffic.
// RL15 - software sets pause enables after reading PHY flow-control resolution.
// RL16 - fully forced setup: PHY forces link; link up proves nothing.
// RL17 - qualified link transitions trigger re-evaluation of rate setup.
// RL18 - software writes duplex and rate after PHY reports link negotiated.
// RL19 - PHY link input is active high.
// RL20 - collision and carrier sense ignored in full duplex.
// RL21 - carrier sense is synchronised before use.
// RL22 - link, rate and duplex controls are synchronised before acting on paths.

package gmm_pkg;

	// ******************************************
	// register map
	// ******************************************
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_SOFTPIN = 8'h08;

	localparam int CTRL_DUPLEX_BIT   = 0;
	localparam int CTRL_FRC_DPX_BIT  = 1;
	localparam int CTRL_FRC_RATE_BIT = 2;
	localparam int CTRL_AUTO_BIT     = 3;
	localparam int CTRL_ATTACH_BIT   = 4;
	localparam int CTRL_RXP_BIT      = 5;
	localparam int CTRL_TXP_BIT      = 6;
	localparam int CTRL_RATE_LSB     = 8;
	localparam int CTRL_IFSEL_LSB    = 10;

	localparam int STAT_DUPLEX_BIT = 0;
	localparam int STAT_LINK_BIT   = 1;
	localparam int STAT_RATE_LSB   = 2;
	localparam int STAT_MODE_BIT   = 4;
	localparam int STAT_TXBUSY_BIT = 5;

	localparam int SOFT_DATA_LSB = 0;
	localparam int SOFT_DIR_LSB  = 8;
	localparam int SOFT_PINS     = 4;

	// ******************************************
	// encodings and reset values
	// ******************************************
	localparam logic [1:0] RATE_10   = 2'h0;
	localparam logic [1:0] RATE_100  = 2'h1;
	localparam logic [1:0] RATE_1000 = 2'h2;
	localparam logic [1:0] IFSEL_GMII = 2'h1;
	localparam logic [1:0] CTRL_RATE_RST  = 2'h0;
	localparam logic [1:0] CTRL_IFSEL_RST = 2'h0;
	localparam logic [3:0] SOFT_RST       = 4'h0;

	// ******************************************
	// rate detection timing
	// ******************************************
	localparam int SYS_CLK_MHZ     = 25;
	localparam int FAST_PERIOD_NS  = 40;
	localparam int SLOW_PERIOD_NS  = 400;
	// a count of system cycles between receive clock rises above GIG_MAX_CYC and at or below this is 100 Mbps
	localparam int FAST_MAX_CYC    = (SLOW_PERIOD_NS * SYS_CLK_MHZ) / 1000 / 2;
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [7:0] GIG_MAX_CYC = 8'h01;

	typedef enum {TX_IDLE, TX_DATA} gmm_tx_e;

	typedef struct packed {
		logic [1:0] ifsel;
		logic [1:0] rate;
		logic       tx_pause;
		logic       rx_pause;
		logic       attach;
		logic       auto_det;
		logic       frc_rate;
		logic       frc_dpx;
		logic       duplex;
	} gmm_ctrl_s;

	typedef struct packed {
		logic [7:0] data;
		logic       dv;
		logic       er;
	} gmm_rx_s;

endpackage : gmm_pkg

// ---- verilog/gmm_sync.sv ----
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: each bit is sampled independently
// Notes:   first stage is read only by the second

`timescale 1ns/1ps

module gmm_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			q_o      <= '0;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end

endmodule : gmm_sync

// ---- verilog/gmm_mac_link.sv ----
// Purpose: MAC side of an external GMII/MII port with link setup controls
// Assumes: PHY clocks slower than half the system clock; pins are asynchronous
// Notes:   gigabit timing is scaled to the system clock divider

`timescale 1ns/1ps

module gmm_mac_link (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// register port
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	// user transmit stream
	input  wire logic [7:0]  tx_data_i,
	input  wire logic        tx_valid_i,
	input  wire logic        tx_last_i,
	output logic             tx_ready_o,
	input  wire logic        pause_req_i,
	// user receive stream
	output logic      [7:0]  rx_data_o,
	output logic             rx_valid_o,
	output logic             rx_end_o,
	output logic             rx_error_o,
	output logic             rx_pause_en_o,
	// PHY pins
	output logic             gtx_clk_o,
	input  wire logic        mii_tx_clock_i,
	output logic      [7:0]  phy_txd_o,
	output logic             phy_tx_en_o,
	output logic             phy_tx_er_o,
	input  wire logic        phy_rx_clk_i,
	input  wire logic [7:0]  phy_rxd_i,
	input  wire logic        phy_rx_dv_i,
	input  wire logic        phy_rx_er_i,
	input  wire logic        phy_crs_i,
	input  wire logic        phy_col_i,
	input  wire logic        phy_link_i,
	// software pins
	input  wire logic [3:0]  soft_pins_i,
	output logic      [3:0]  soft_pins_o,
	output logic      [3:0]  soft_pins_oe_o
);

	// ******************************************
	// pin synchronisers
	// ******************************************
	gmm_pkg::gmm_rx_s rx_pin;
	gmm_pkg::gmm_rx_s rx_s;
	logic             txc_s;
	logic             rxc_s;
	logic             crs_s;
	logic             col_s;
	logic             link_s;
	logic [3:0]       soft_s;

	assign rx_pin = '{data: phy_rxd_i, dv: phy_rx_dv_i, er: phy_rx_er_i};

	// receive clock and data pass the same delay, so edges stay aligned
	gmm_sync #(.WIDTH(11)) u_sync_rx (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({phy_rx_clk_i, rx_pin}),
		.q_o   ({rxc_s, rx_s})
	); // [RL3]

	gmm_sync #(.WIDTH(4)) u_sync_ctl (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({mii_tx_clock_i, phy_crs_i, phy_col_i, phy_link_i}),
		.q_o   ({txc_s, crs_s, col_s, link_s})
	); // [RL21] [RL22]

	gmm_sync #(.WIDTH(4)) u_sync_soft (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (soft_pins_i),
		.q_o   (soft_s)
	);

	// ******************************************
	// registers
	// ******************************************
	gmm_pkg::gmm_ctrl_s ctrl_reg;
	logic [3:0]         soft_data_reg;
	logic [3:0]         soft_dir_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= '{ifsel: gmm_pkg::CTRL_IFSEL_RST, rate: gmm_pkg::CTRL_RATE_RST,
			              default: 1'b0};
		end else if (reg_wr_i && reg_addr_i == gmm_pkg::ADDR_CTRL) begin
			ctrl_reg.duplex   <= reg_wdata_i[gmm_pkg::CTRL_DUPLEX_BIT];
			ctrl_reg.frc_dpx  <= reg_wdata_i[gmm_pkg::CTRL_FRC_DPX_BIT];
			ctrl_reg.frc_rate <= reg_wdata_i[gmm_pkg::CTRL_FRC_RATE_BIT];
			ctrl_reg.auto_det <= reg_wdata_i[gmm_pkg::CTRL_AUTO_BIT];
			ctrl_reg.attach   <= reg_wdata_i[gmm_pkg::CTRL_ATTACH_BIT];
			ctrl_reg.rx_pause <= reg_wdata_i[gmm_pkg::CTRL_RXP_BIT];
			ctrl_reg.tx_pause <= reg_wdata_i[gmm_pkg::CTRL_TXP_BIT];
			ctrl_reg.rate     <= reg_wdata_i[gmm_pkg::CTRL_RATE_LSB +: 2];
			ctrl_reg.ifsel    <= reg_wdata_i[gmm_pkg::CTRL_IFSEL_LSB +: 2];
		end
	end

	// software pins stand in for the missing management pins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			soft_data_reg <= gmm_pkg::SOFT_RST;
			soft_dir_reg  <= gmm_pkg::SOFT_RST;
		end else if (reg_wr_i && reg_addr_i == gmm_pkg::ADDR_SOFTPIN) begin
			soft_data_reg <= reg_wdata_i[gmm_pkg::SOFT_DATA_LSB +: gmm_pkg::SOFT_PINS];
			soft_dir_reg  <= reg_wdata_i[gmm_pkg::SOFT_DIR_LSB +: gmm_pkg::SOFT_PINS];
		end
	end // [RL6]

	assign soft_pins_o    = soft_data_reg;
	assign soft_pins_oe_o = soft_dir_reg;

	// ******************************************
	// link qualification and rate selection
	// ******************************************
	logic       mode_ok;
	logic       link_up;
	logic       link_up_d_reg;
	logic       link_active;
	logic [1:0] meas_rate_reg;
	logic [1:0] auto_rate_reg;
	logic [1:0] eff_rate;
	logic       eff_full;
	logic       half_dup;
	logic       is_gig;
	logic [7:0] per_cnt_reg;
	logic       rxc_d_reg;
	logic       txc_d_reg;
	logic       rx_rise;
	logic       tx_rise;

	assign mode_ok     = ctrl_reg.ifsel == gmm_pkg::IFSEL_GMII; // [RL9]
	assign link_up     = link_s & ctrl_reg.attach; // [RL13] [RL19]
	assign link_active = link_up & mode_ok; // [RL14]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rxc_d_reg <= 1'b0;
			txc_d_reg <= 1'b0;
		end else begin
			rxc_d_reg <= rxc_s;
			txc_d_reg <= txc_s;
		end
	end

	assign rx_rise = rxc_s & ~rxc_d_reg;
	assign tx_rise = txc_s & ~txc_d_reg;

	// receive clock period measurement for auto-detect
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			per_cnt_reg   <= 8'h00;
			meas_rate_reg <= gmm_pkg::RATE_10;
		end else if (rx_rise) begin
			per_cnt_reg <= 8'h00;
			if (per_cnt_reg <= gmm_pkg::GIG_MAX_CYC) begin
				meas_rate_reg <= gmm_pkg::RATE_1000;
			end else if (per_cnt_reg <= 8'(gmm_pkg::FAST_MAX_CYC)) begin
				meas_rate_reg <= gmm_pkg::RATE_100;
			end else begin
				meas_rate_reg <= gmm_pkg::RATE_10;
			end
		end else if (per_cnt_reg != gmm_pkg::CNT_MAX) begin
			per_cnt_reg <= per_cnt_reg + 8'h01;
		end
	end // [RL12]

	// detected rate re-evaluated on each qualified link transition
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link_up_d_reg <= 1'b0;
			auto_rate_reg <= gmm_pkg::RATE_10;
		end else begin
			link_up_d_reg <= link_up;
			if (link_up != link_up_d_reg) begin
				auto_rate_reg <= meas_rate_reg;
			end
		end
	end // [RL17]

	always_comb begin
		if (ctrl_reg.frc_rate) begin
			eff_rate = ctrl_reg.rate; // [RL11]
		end else if (ctrl_reg.auto_det) begin
			eff_rate = auto_rate_reg; // [RL12] [RL7]
		end else begin
			eff_rate = ctrl_reg.rate;
		end
	end

	assign is_gig   = eff_rate == gmm_pkg::RATE_1000;
	// no duplex pin from the PHY: unforced duplex defaults to full
	assign eff_full = is_gig | ~ctrl_reg.frc_dpx | ctrl_reg.duplex; // [RL1] [RL10] [RL7]
	assign half_dup = ~eff_full;

	// ******************************************
	// transmit path
	// ******************************************
	gmm_pkg::gmm_tx_e tx_state_reg;
	logic             gtx_reg;
	logic             tick;
	logic             nib_hi_reg;
	logic             last_reg;
	logic [3:0]       hi_nib_reg;
	logic             start_ok;
	logic             take;

	// gigabit transmit clock divided from the system clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gtx_reg <= 1'b0;
		end else begin
			gtx_reg <= is_gig & mode_ok & ~gtx_reg;
		end
	end // [RL2]

	assign gtx_clk_o = gtx_reg;
	// data changes as the gigabit clock falls, PHY samples at its rise
	assign tick = is_gig ? gtx_reg : tx_rise; // [RL2] [RL4]

	assign start_ok = link_active & ~(half_dup & crs_s) & ~(ctrl_reg.tx_pause & pause_req_i);

	always_comb begin
		if (!tick) begin
			take = 1'b0;
		end else if (tx_state_reg == gmm_pkg::TX_DATA) begin
			take = ~nib_hi_reg & ~last_reg & link_active;
		end else begin
			take = start_ok;
		end
	end

	assign tx_ready_o = take;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_state_reg <= gmm_pkg::TX_IDLE;
			phy_txd_o    <= 8'h00;
			phy_tx_en_o  <= 1'b0;
			phy_tx_er_o  <= 1'b0;
			nib_hi_reg   <= 1'b0;
			last_reg     <= 1'b0;
			hi_nib_reg   <= 4'h0;
		end else if (tick) begin
			case (tx_state_reg)
				gmm_pkg::TX_IDLE: begin
					phy_tx_er_o <= 1'b0;
					if (take && tx_valid_i) begin
						tx_state_reg <= gmm_pkg::TX_DATA;
						phy_tx_en_o  <= 1'b1;
						phy_txd_o    <= is_gig ? tx_data_i : {4'h0, tx_data_i[3:0]};
						hi_nib_reg   <= tx_data_i[7:4];
						nib_hi_reg   <= ~is_gig;
						last_reg     <= tx_last_i;
					end else begin
						phy_tx_en_o <= 1'b0;
						phy_txd_o   <= 8'h00;
					end
				end
				gmm_pkg::TX_DATA: begin
					if (nib_hi_reg) begin
						phy_txd_o  <= {4'h0, hi_nib_reg}; // [RL4]
						nib_hi_reg <= 1'b0;
					end else if (take && tx_valid_i) begin
						phy_txd_o  <= is_gig ? tx_data_i : {4'h0, tx_data_i[3:0]};
						hi_nib_reg <= tx_data_i[7:4];
						nib_hi_reg <= ~is_gig;
						last_reg   <= tx_last_i;
					end else begin
						// underrun or link loss marks the frame bad at gigabit
						tx_state_reg <= gmm_pkg::TX_IDLE;
						phy_tx_en_o  <= 1'b0;
						phy_tx_er_o  <= ~last_reg & is_gig; // [RL2]
						phy_txd_o    <= 8'h00;
						last_reg     <= 1'b0;
					end
				end
				default: begin
					tx_state_reg <= gmm_pkg::TX_IDLE;
					phy_tx_en_o  <= 1'b0;
				end
			endcase
		end
	end

	// ******************************************
	// receive path
	// ******************************************
	logic       rx_act_reg;
	logic       rx_half_reg;
	logic [3:0] rx_lo_reg;
	logic       rx_bad_reg;
	logic       col_seen;

	// collision only counts in half duplex
	assign col_seen = half_dup & col_s; // [RL20]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_act_reg  <= 1'b0;
			rx_half_reg <= 1'b0;
			rx_lo_reg   <= 4'h0;
			rx_bad_reg  <= 1'b0;
			rx_data_o   <= 8'h00;
			rx_valid_o  <= 1'b0;
			rx_end_o    <= 1'b0;
			rx_error_o  <= 1'b0;
		end else begin
			rx_valid_o <= 1'b0;
			rx_end_o   <= 1'b0;
			if (rx_rise && link_active) begin // [RL14]
				if (rx_s.dv) begin
					rx_act_reg <= 1'b1;
					rx_bad_reg <= rx_bad_reg | rx_s.er | col_seen;
					if (is_gig) begin
						rx_data_o  <= rx_s.data; // [RL3]
						rx_valid_o <= 1'b1;
					end else if (rx_half_reg) begin
						rx_data_o   <= {rx_s.data[3:0], rx_lo_reg}; // [RL5]
						rx_valid_o  <= 1'b1;
						rx_half_reg <= 1'b0;
					end else begin
						rx_lo_reg   <= rx_s.data[3:0]; // [RL5]
						rx_half_reg <= 1'b1;
					end
				end else if (rx_act_reg) begin
					// odd trailing nibble is dropped and flags the frame
					rx_end_o    <= 1'b1;
					rx_error_o  <= rx_bad_reg | rx_half_reg;
					rx_act_reg  <= 1'b0;
					rx_half_reg <= 1'b0;
					rx_bad_reg  <= 1'b0;
				end
			end else if (!link_active && rx_act_reg) begin
				rx_end_o    <= 1'b1;
				rx_error_o  <= 1'b1;
				rx_act_reg  <= 1'b0;
				rx_half_reg <= 1'b0;
				rx_bad_reg  <= 1'b0;
			end
		end
	end

	assign rx_pause_en_o = ctrl_reg.rx_pause;

	// ******************************************
	// register read
	// ******************************************
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (reg_addr_i)
			gmm_pkg::ADDR_CTRL: begin
				rd_mux[gmm_pkg::CTRL_DUPLEX_BIT]    = ctrl_reg.duplex;
				rd_mux[gmm_pkg::CTRL_FRC_DPX_BIT]   = ctrl_reg.frc_dpx;
				rd_mux[gmm_pkg::CTRL_FRC_RATE_BIT]  = ctrl_reg.frc_rate;
				rd_mux[gmm_pkg::CTRL_AUTO_BIT]      = ctrl_reg.auto_det;
				rd_mux[gmm_pkg::CTRL_ATTACH_BIT]    = ctrl_reg.attach;
				rd_mux[gmm_pkg::CTRL_RXP_BIT]       = ctrl_reg.rx_pause;
				rd_mux[gmm_pkg::CTRL_TXP_BIT]       = ctrl_reg.tx_pause;
				rd_mux[gmm_pkg::CTRL_RATE_LSB +: 2] = ctrl_reg.rate;
				rd_mux[gmm_pkg::CTRL_IFSEL_LSB +: 2] = ctrl_reg.ifsel;
			end
			gmm_pkg::ADDR_STATUS: begin
				rd_mux[gmm_pkg::STAT_DUPLEX_BIT]    = ctrl_reg.duplex; // [RL10]
				rd_mux[gmm_pkg::STAT_LINK_BIT]      = link_up; // [RL13]
				rd_mux[gmm_pkg::STAT_RATE_LSB +: 2] = eff_rate; // [RL11] [RL12]
				rd_mux[gmm_pkg::STAT_MODE_BIT]      = mode_ok;
				rd_mux[gmm_pkg::STAT_TXBUSY_BIT]    = phy_tx_en_o;
			end
			gmm_pkg::ADDR_SOFTPIN: begin
				rd_mux[gmm_pkg::SOFT_DATA_LSB +: 4] = soft_s;
				rd_mux[gmm_pkg::SOFT_DIR_LSB +: 4]  = soft_dir_reg;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rd_mux;
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end

endmodule : gmm_mac_link

// ---- tb/gmm_phy_model.sv ----
// Purpose: behavioural PHY on the far side of the GMII/MII pins
// Assumes: one free-running PHY clock serves receive and MII transmit
// Notes:   upper receive lines carry junk that the MAC must ignore

`timescale 1ns/1ps

module gmm_phy_model (
	input  wire logic [9:0] half_ns_i,
	input  wire logic [7:0] txd_i,
	input  wire logic       tx_en_i,
	output logic            clk_o,
	output logic [7:0]      rxd_o,
	output logic            rx_dv_o,
	output logic            rx_er_o
);
	logic [7:0] got_q[$];
	logic [3:0] low_reg;
	logic       odd_reg;

	initial begin
		clk_o = 1'b0;
		rxd_o = 8'h00;
		rx_dv_o = 1'b0;
		rx_er_o = 1'b0;
		odd_reg = 1'b0;
		#7;
		forever begin
			#(half_ns_i);
			clk_o = ~clk_o;
		end
	end

	// low nibble first on the transmit clock
	always @(posedge clk_o) begin
		if (tx_en_i === 1'b1) begin
			if (odd_reg)
				got_q.push_back({txd_i[3:0], low_reg});
			low_reg = txd_i[3:0];
			odd_reg = ~odd_reg;
		end else
			odd_reg = 1'b0;
	end

	// changes on the falling edge, inverted lines once released
	task frame(input logic [15:0] nib, input int n);
		for (int k = 0; k < n; k++) begin
			@(negedge clk_o);
			rxd_o = {~nib[4*k +: 4], nib[4*k +: 4]};
			rx_dv_o = 1'b1;
		end
		@(negedge clk_o);
		rx_dv_o = 1'b0;
		rxd_o = ~rxd_o;
	endtask : frame
endmodule : gmm_phy_model

// ---- tb/gmm_mac_link_checker.sv ----
// Purpose: port-level checks of link setup and data path gating
// Assumes: control word shadowed from register writes
// Notes:   bound into the block below

`timescale 1ns/1ps

module gmm_mac_link_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        tx_ready_o,
	input wire logic        pause_req_i,
	input wire logic        rx_valid_o,
	input wire logic        gtx_clk_o,
	input wire logic [7:0]  phy_txd_o,
	input wire logic        phy_tx_en_o,
	input wire logic        phy_link_i
);
	logic [11:0] ctrl_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ctrl_reg <= 12'h000;
		else if (reg_wr_i && reg_addr_i == gmm_pkg::ADDR_CTRL)
			ctrl_reg <= reg_wdata_i[11:0] & 12'hf7f;
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence rd_stat;
		reg_rd_i && reg_addr_i == gmm_pkg::ADDR_STATUS;
	endsequence

	a_duplex_mirror: assert property (rd_stat |=> reg_rdata_o[0] == $past(ctrl_reg[0]))
		else $error("duplex status differs from setting");
	a_forced_rate: assert property (rd_stat ##0 ctrl_reg[2] |=>
		reg_rdata_o[3:2] == $past(ctrl_reg[9:8])) else $error("forced rate not reported");
	a_link_gate: assert property (rd_stat ##0 !ctrl_reg[4] |=> !reg_rdata_o[1])
		else $error("link up without attach");
	a_link_low: assert property (!phy_link_i [*4] ##0 rd_stat |=> !reg_rdata_o[1])
		else $error("link up with link input low");
	a_link_up: assert property (phy_link_i [*4] ##0 rd_stat ##0 ctrl_reg[4] |=>
		reg_rdata_o[1]) else $error("link down with link and attach");
	a_mode_bit: assert property (rd_stat |=>
		reg_rdata_o[4] == ($past(ctrl_reg[11:10]) == gmm_pkg::IFSEL_GMII))
		else $error("mode bit wrong");
	a_gtx_off: assert property ((ctrl_reg[11:10] != gmm_pkg::IFSEL_GMII) [*3] |-> !gtx_clk_o)
		else $error("transmit clock runs outside port mode");
	a_mii_nibble: assert property ((ctrl_reg[11:10] == gmm_pkg::IFSEL_GMII && ctrl_reg[2] &&
		ctrl_reg[9:8] != gmm_pkg::RATE_1000) [*3] |-> phy_txd_o[7:4] == 4'h0)
		else $error("upper data lines driven at 10/100");
	a_attach_tx: assert property (!ctrl_reg[4] && !phy_tx_en_o |-> !tx_ready_o)
		else $error("frame start without attach");
	a_pause_hold: assert property (ctrl_reg[6] && pause_req_i && $past(pause_req_i) &&
		!phy_tx_en_o |-> !tx_ready_o) else $error("frame start during pause");
	a_rx_pulse: assert property (rx_valid_o |=> !rx_valid_o)
		else $error("receive byte pulse too long");
endmodule : gmm_mac_link_checker

bind gmm_mac_link gmm_mac_link_checker u_gmm_mac_link_checker (
	.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.tx_ready_o(tx_ready_o), .pause_req_i(pause_req_i), .rx_valid_o(rx_valid_o),
	.gtx_clk_o(gtx_clk_o), .phy_txd_o(phy_txd_o), .phy_tx_en_o(phy_tx_en_o),
	.phy_link_i(phy_link_i));

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the GMII/MII link setup block
// Assumes: PHY model supplies both link clocks
// Notes:   control words use the block's register map

`timescale 1ns/1ps

module testbench;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [7:0]  tx_data_i = 8'h00;
	logic        tx_valid_i = 1'b0;
	logic        tx_last_i = 1'b0;
	logic        pause_req_i = 1'b0;
	logic        phy_crs_i = 1'b0;
	logic        phy_col_i = 1'b0;
	logic        phy_link_i = 1'b0;
	logic [9:0]  half_ns = 10'h0a0;
	logic        err_seen = 1'b0;
	logic [31:0] reg_rdata_o;
	logic        tx_ready_o, rx_valid_o, rx_end_o, rx_error_o, rx_pause_en_o, gtx_clk_o;
	logic        phy_tx_en_o, phy_tx_er_o, link_clk, rx_dv, rx_er, g;
	logic [7:0]  rx_data_o, phy_txd_o, rxd;
	logic [3:0]  soft_pins_i, soft_pins_o, soft_pins_oe_o;
	logic [7:0]  rx_q[$];
	int          fails = 0;
	int          comparisons = 0;
	int          n;

	always #20 clk_i = ~clk_i;
	// pin wire: driven bits follow the block, others pulled to 9
	assign soft_pins_i = (soft_pins_oe_o & soft_pins_o) | (~soft_pins_oe_o & 4'h9);

	always @(posedge clk_i) begin
		if (rx_valid_o === 1'b1)
			rx_q.push_back(rx_data_o);
		if (rx_end_o === 1'b1)
			err_seen = rx_error_o;
	end

	gmm_mac_link u_gmm_mac_link (
		.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_last_i(tx_last_i),
		.tx_ready_o(tx_ready_o), .pause_req_i(pause_req_i), .rx_data_o(rx_data_o),
		.rx_valid_o(rx_valid_o), .rx_end_o(rx_end_o), .rx_error_o(rx_error_o),
		.rx_pause_en_o(rx_pause_en_o), .gtx_clk_o(gtx_clk_o), .mii_tx_clock_i(link_clk),
		.phy_txd_o(phy_txd_o), .phy_tx_en_o(phy_tx_en_o), .phy_tx_er_o(phy_tx_er_o),
		.phy_rx_clk_i(link_clk), .phy_rxd_i(rxd), .phy_rx_dv_i(rx_dv), .phy_rx_er_i(rx_er),
		.phy_crs_i(phy_crs_i), .phy_col_i(phy_col_i), .phy_link_i(phy_link_i),
		.soft_pins_i(soft_pins_i), .soft_pins_o(soft_pins_o), .soft_pins_oe_o(soft_pins_oe_o));

	gmm_phy_model u_gmm_phy_model (.half_ns_i(half_ns), .txd_i(phy_txd_o),
		.tx_en_i(phy_tx_en_o), .clk_o(link_clk), .rxd_o(rxd), .rx_dv_o(rx_dv), .rx_er_o(rx_er));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	task rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, e);
	endtask : rchk

	task send(input logic [7:0] b, input logic l);
		tx_data_i <= b;
		tx_valid_i <= 1'b1;
		tx_last_i <= l;
		n = 0;
		#1;
		while (tx_ready_o !== 1'b1 && n < 400) begin
			@(posedge clk_i);
			#1 n++;
		end
		chk(n < 400, 1'b1);
		@(posedge clk_i);
	endtask : send

	task stop_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(gmm_pkg::ADDR_CTRL, 32'h0000_0000);
		rchk(gmm_pkg::ADDR_STATUS, 32'h0000_0000);
		wr(8'h0c, 32'hffff_ffff);
		rchk(8'h0c, 32'h0000_0000);
		rchk(gmm_pkg::ADDR_CTRL, 32'h0000_0000);
		wr(gmm_pkg::ADDR_CTRL, 32'hffff_ffff);
		rchk(gmm_pkg::ADDR_CTRL, 32'h0000_0f7f);
		chk(rx_pause_en_o, 1'b1);
		$display("test registers done");
		phy_link_i <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			wr(gmm_pkg::ADDR_CTRL, 32'h0000_0406 | 32'(i % 3 << 8) | 32'(i / 3) | 32'((i & 1) << 4));
			repeat (4) @(posedge clk_i);
			rchk(gmm_pkg::ADDR_STATUS, 32'(i / 3 | (i & 1) << 1 | i % 3 << 2 | 16));
			if (i % 3 == 2) begin
				#1 g = gtx_clk_o;
				@(posedge clk_i);
				#1 chk(gtx_clk_o ^ g, 1'b1);
			end
		end
		phy_link_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rchk(gmm_pkg::ADDR_STATUS, 32'h0000_0019);
		$display("test forced setup done");
		for (int i = 0; i < 2; i++) begin
			half_ns <= 10'h050 << i;
			phy_link_i <= 1'b0;
			wr(gmm_pkg::ADDR_CTRL, 32'h0000_061b);
			repeat (40) @(posedge clk_i);
			phy_link_i <= 1'b1;
			repeat (40) @(posedge clk_i);
			rchk(gmm_pkg::ADDR_STATUS, 32'h0000_0013 |
				32'(i ? gmm_pkg::RATE_10 : gmm_pkg::RATE_100) << 2);
		end
		$display("test rate detect done");
		pause_req_i <= 1'b1;
		phy_crs_i <= 1'b1;
		wr(gmm_pkg::ADDR_CTRL, 32'h0000_0557);
		tx_valid_i <= 1'b1;
		n = 0;
		repeat (60) begin
			@(posedge clk_i);
			#1 n += int'(tx_ready_o === 1'b1);
		end
		chk(n, 0);
		pause_req_i <= 1'b0;
		send(8'h3c, 1'b0);
		send(8'h81, 1'b1);
		tx_valid_i <= 1'b0;
		repeat (120) @(posedge clk_i);
		chk(u_gmm_phy_model.got_q.size(), 2);
		chk(u_gmm_phy_model.got_q[0], 8'h3c);
		chk(u_gmm_phy_model.got_q[1], 8'h81);
		chk({phy_tx_er_o, rx_pause_en_o}, 2'h0);
		$display("test transmit done");
		phy_col_i <= 1'b1;
		wr(gmm_pkg::ADDR_CTRL, 32'h0000_0556);
		u_gmm_phy_model.frame(16'h813c, 4);
		repeat (40) @(posedge clk_i);
		chk(rx_q.size(), 2);
		chk(rx_q[0], 8'h3c);
		chk(rx_q[1], 8'h81);
		chk(err_seen, 1'b1);
		wr(gmm_pkg::ADDR_CTRL, 32'h0000_0557);
		u_gmm_phy_model.frame(16'h813c, 4);
		repeat (40) @(posedge clk_i);
		chk(err_seen, 1'b0);
		u_gmm_phy_model.frame(16'h0005, 3);
		repeat (40) @(posedge clk_i);
		chk(err_seen, 1'b1);
		$display("test receive done");
		wr(gmm_pkg::ADDR_SOFTPIN, 32'h0000_0a05);
		repeat (4) @(posedge clk_i);
		chk(soft_pins_o, 4'h5);
		chk(soft_pins_oe_o, 4'ha);
		rchk(gmm_pkg::ADDR_SOFTPIN, 32'h0000_0a01);
		$display("test soft pins done");
		stop_test();
	end

	initial begin
		#2_000_000;
		fails++;
		$display("watchdog expired at %0t", $time);
		stop_test();
	end
endmodule : testbench
